// ---- logic/timer8_defines.svh ----
`ifndef TIMER8_DEFINES_SVH
`define TIMER8_DEFINES_SVH

// Data-space byte offsets; I/O-space offset is data offset minus IO delta
`define IO_DELTA          8'h20
`define CTRL_A_OFS        8'h44
`define CTRL_B_OFS        8'h45
`define COUNT_OFS         8'h46
`define CMP_A_OFS         8'h47
`define CMP_B_OFS         8'h48

// Field positions, control register A
`define CHAN_A_MODE_HI    7
`define CHAN_A_MODE_LO    6
`define CHAN_B_MODE_HI    5
`define CHAN_B_MODE_LO    4
`define WAVE_SEL_HI       1
`define WAVE_SEL_LO       0
// Field position, control register B
`define WAVE_MSB_POS      3

// Reset values
`define CTRL_A_RESET      8'h00
`define CTRL_B_RESET      8'h00
`define COUNT_RESET       8'h00
`define CMP_RESET         8'h00

// Counter limits
`define COUNT_MAX         8'hff
`define COUNT_BOTTOM      8'h00
`define COUNT_STEP        8'h01

`endif

// ---- logic/timer8_pkg.sv ----
package timer8_pkg;

  typedef enum logic [2:0] {
    MODE_NORMAL   = 3'h0,
    MODE_PC_FIXED = 3'h1,
    MODE_CTC      = 3'h2,
    MODE_FAST_FIX = 3'h3,
    MODE_RSV4     = 3'h4,
    MODE_PC_CMPA  = 3'h5,
    MODE_RSV6     = 3'h6,
    MODE_FAST_CMP = 3'h7
  } wave_mode_type;

  typedef enum logic [1:0] {
    CLS_NONPWM = 2'h0,
    CLS_FAST   = 2'h1,
    CLS_PHASE  = 2'h3
  } mode_class_type;

  typedef enum logic {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } count_dir_type;

  typedef struct packed {
    logic [1:0]    chan_a_output_mode;
    logic [1:0]    chan_b_output_mode;
    logic [1:0]    wave_mode_sel;
    logic          wave_mode_msb;
    logic [7:0]    count_value;
    logic [7:0]    cmp_a_buf;
    logic [7:0]    cmp_a;
    logic [7:0]    cmp_b_buf;
    logic [7:0]    cmp_b;
    count_dir_type dir;
    logic          block;
    logic          overflow_flag;
    logic [7:0]    rdata;
    logic [1:0]    pin;
    logic [1:0]    pin_oe_n;
  } ctrl_state_type;

  typedef struct packed {
    logic wave;
  } chan_state_type;

endpackage

// ---- logic/wave_channel.sv ----
`timescale 1ns/1ps
module wave_channel #(
  parameter bit IS_CHAN_A = 1'b1
) (
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_srst,
  input  wire timer8_pkg::mode_class_type i_class,
  input  wire logic [1:0]              i_code,
  input  wire logic                    i_mode_msb,
  input  wire logic                    i_match,
  input  wire logic                    i_at_bottom,
  input  wire logic                    i_at_top,
  input  wire logic                    i_up,
  input  wire logic                    i_cmp_eq_top,
  output      logic                    o_wave,
  output      logic                    o_connected
);

  timer8_pkg::chan_state_type s_q;
  timer8_pkg::chan_state_type s_d;
  logic                       toggle_ok;

  always_comb begin
    s_d       = s_q;
    toggle_ok = IS_CHAN_A && i_mode_msb;
    case (i_class)
      timer8_pkg::CLS_NONPWM: begin
        if (i_match) begin
          case (i_code)
            2'h1:    s_d.wave = ~s_q.wave;
            2'h2:    s_d.wave = 1'b0;
            2'h3:    s_d.wave = 1'b1;
            default: s_d.wave = s_q.wave;
          endcase
        end
      end
      timer8_pkg::CLS_FAST: begin
        if (i_code == 2'h1) begin
          if (toggle_ok && i_match) begin
            s_d.wave = ~s_q.wave;
          end
        end else if (i_code[1]) begin
          if (i_at_bottom) begin
            s_d.wave = ~i_code[0];
          end else if (i_match && !i_cmp_eq_top) begin
            s_d.wave = i_code[0];
          end
        end
      end
      timer8_pkg::CLS_PHASE: begin
        if (i_code == 2'h1) begin
          if (toggle_ok && i_match) begin
            s_d.wave = ~s_q.wave;
          end
        end else if (i_code[1]) begin
          if (i_cmp_eq_top) begin
            if (i_at_top) begin
              s_d.wave = ~i_code[0];
            end
          end else if (i_match) begin
            s_d.wave = i_up ? i_code[0] : ~i_code[0];
          end
        end
      end
      default: s_d.wave = s_q.wave;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Code 01 connects in PWM classes only where toggling is available
  always_comb begin
    o_connected = (i_code != 2'h0);
    if (i_class != timer8_pkg::CLS_NONPWM && i_code == 2'h1) begin
      o_connected = toggle_ok;
    end
  end

  assign o_wave = s_q.wave;

endmodule

// ---- logic/timer8_waveform_output_control.sv ----
`timescale 1ns/1ps
`include "timer8_defines.svh"
module timer8_waveform_output_control (
  input  wire logic       i_ref_clk,
  input  wire logic       i_srst,
  input  wire logic       i_tick,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_we,
  input  wire logic       i_re,
  output      logic [7:0] o_rdata,
  input  wire logic       i_port_out_a,
  input  wire logic       i_port_dir_a,
  input  wire logic       i_port_out_b,
  input  wire logic       i_port_dir_b,
  output      logic       o_pin_a,
  output      logic       o_pin_a_oe_n,
  output      logic       o_pin_b,
  output      logic       o_pin_b_oe_n,
  output      logic       o_wave_out_a,
  output      logic       o_wave_out_b,
  output      logic       o_overflow_flag,
  output      logic [7:0] o_count_value
);

  timer8_pkg::ctrl_state_type s_q;
  timer8_pkg::ctrl_state_type s_d;
  timer8_pkg::wave_mode_type  mode;
  timer8_pkg::mode_class_type cls;
  logic [7:0]                 top;
  logic                       at_top;
  logic                       immediate;
  logic                       pc_top_evt;
  logic                       fast_wrap_evt;
  logic [1:0]                 match;
  logic [1:0]                 eq_top;
  logic [1:0]                 wave;
  logic [1:0]                 connected;
  logic [1:0]                 port_out;
  logic [1:0]                 port_dir;
  logic [1:0]                 code [2];
  logic [7:0]                 cmp  [2];

  // Accepts a register's data-space or I/O-space address
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] ofs);
    hit = (addr == ofs) || (addr == 8'(ofs - `IO_DELTA));
  endfunction

  assign mode = timer8_pkg::wave_mode_type'({s_q.wave_mode_msb,
                                             s_q.wave_mode_sel});

  always_comb begin
    case (mode)
      timer8_pkg::MODE_PC_FIXED,
      timer8_pkg::MODE_PC_CMPA:  cls = timer8_pkg::CLS_PHASE;
      timer8_pkg::MODE_FAST_FIX,
      timer8_pkg::MODE_FAST_CMP: cls = timer8_pkg::CLS_FAST;
      default:                   cls = timer8_pkg::CLS_NONPWM;
    endcase
  end

  always_comb begin
    case (mode)
      timer8_pkg::MODE_CTC,
      timer8_pkg::MODE_PC_CMPA,
      timer8_pkg::MODE_FAST_CMP: top = s_q.cmp_a;
      default:                   top = `COUNT_MAX;
    endcase
  end

  assign at_top        = (s_q.count_value == top);
  assign immediate     = (cls == timer8_pkg::CLS_NONPWM);
  assign pc_top_evt    = i_tick && at_top && s_q.dir == timer8_pkg::DIR_UP
                         && cls == timer8_pkg::CLS_PHASE;
  assign fast_wrap_evt = i_tick && at_top && cls == timer8_pkg::CLS_FAST;
  assign code[0]       = s_q.chan_a_output_mode;
  assign code[1]       = s_q.chan_b_output_mode;
  assign cmp[0]        = s_q.cmp_a;
  assign cmp[1]        = s_q.cmp_b;
  assign port_out      = {i_port_out_b, i_port_out_a};
  assign port_dir      = {i_port_dir_b, i_port_dir_a};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      assign match[g]  = i_tick && !s_q.block
                         && (s_q.count_value == cmp[g]);
      assign eq_top[g] = (cmp[g] == top);
      wave_channel #(
        .IS_CHAN_A (g == 0)
      ) u_chan (
        .i_ref_clk    (i_ref_clk),
        .i_srst       (i_srst),
        .i_class      (cls),
        .i_code       (code[g]),
        .i_mode_msb   (s_q.wave_mode_msb),
        .i_match      (match[g]),
        .i_at_bottom  (fast_wrap_evt),
        .i_at_top     (pc_top_evt),
        .i_up         (s_q.dir == timer8_pkg::DIR_UP),
        .i_cmp_eq_top (eq_top[g]),
        .o_wave       (wave[g]),
        .o_connected  (connected[g])
      );
    end
  endgenerate

  always_comb begin
    s_d               = s_q;
    s_d.overflow_flag = 1'b0;
    if (i_tick) begin
      s_d.block = 1'b0;
      case (cls)
        timer8_pkg::CLS_PHASE: begin
          if (s_q.dir == timer8_pkg::DIR_UP) begin
            if (at_top) begin
              s_d.dir         = timer8_pkg::DIR_DOWN;
              s_d.count_value = s_q.count_value - `COUNT_STEP;
            end else begin
              s_d.count_value = s_q.count_value + `COUNT_STEP;
            end
          end else if (s_q.count_value == `COUNT_BOTTOM) begin
            s_d.dir           = timer8_pkg::DIR_UP;
            s_d.count_value   = s_q.count_value + `COUNT_STEP;
            s_d.overflow_flag = 1'b1;
          end else begin
            s_d.count_value = s_q.count_value - `COUNT_STEP;
          end
        end
        default: begin
          s_d.dir = timer8_pkg::DIR_UP;
          if (at_top && mode != timer8_pkg::MODE_NORMAL) begin
            s_d.count_value = `COUNT_BOTTOM;
          end else begin
            s_d.count_value = s_q.count_value + `COUNT_STEP;
          end
          if (mode == timer8_pkg::MODE_FAST_CMP) begin
            s_d.overflow_flag = at_top;
          end else begin
            s_d.overflow_flag = (s_q.count_value == `COUNT_MAX);
          end
        end
      endcase
    end
    // Compare registers double-buffered in PWM modes; non-PWM modes copy the buffer into them every clock
    if (immediate || pc_top_evt || fast_wrap_evt) begin
      s_d.cmp_a = s_q.cmp_a_buf;
      s_d.cmp_b = s_q.cmp_b_buf;
    end
    if (i_we) begin
      if (hit(i_addr, `CTRL_A_OFS)) begin
        s_d.chan_a_output_mode = i_wdata[`CHAN_A_MODE_HI:`CHAN_A_MODE_LO];
        s_d.chan_b_output_mode = i_wdata[`CHAN_B_MODE_HI:`CHAN_B_MODE_LO];
        s_d.wave_mode_sel      = i_wdata[`WAVE_SEL_HI:`WAVE_SEL_LO];
      end
      if (hit(i_addr, `CTRL_B_OFS)) begin
        s_d.wave_mode_msb = i_wdata[`WAVE_MSB_POS];
      end
      if (hit(i_addr, `COUNT_OFS)) begin
        s_d.count_value = i_wdata;
        s_d.block       = 1'b1;
      end
      if (hit(i_addr, `CMP_A_OFS)) begin
        s_d.cmp_a_buf = i_wdata;
      end
      if (hit(i_addr, `CMP_B_OFS)) begin
        s_d.cmp_b_buf = i_wdata;
      end
    end
    if (i_re) begin
      s_d.rdata = 8'h00;
      if (hit(i_addr, `CTRL_A_OFS)) begin
        s_d.rdata[`CHAN_A_MODE_HI:`CHAN_A_MODE_LO] = s_q.chan_a_output_mode;
        s_d.rdata[`CHAN_B_MODE_HI:`CHAN_B_MODE_LO] = s_q.chan_b_output_mode;
        s_d.rdata[`WAVE_SEL_HI:`WAVE_SEL_LO]       = s_q.wave_mode_sel;
      end
      if (hit(i_addr, `CTRL_B_OFS)) begin
        s_d.rdata[`WAVE_MSB_POS] = s_q.wave_mode_msb;
      end
      if (hit(i_addr, `COUNT_OFS)) begin
        s_d.rdata = s_q.count_value;
      end
      if (hit(i_addr, `CMP_A_OFS)) begin
        s_d.rdata = s_q.cmp_a_buf;
      end
      if (hit(i_addr, `CMP_B_OFS)) begin
        s_d.rdata = s_q.cmp_b_buf;
      end
    end
    // Pin takes waveform when connected, port value otherwise
    for (int i = 0; i < 2; i++) begin
      s_d.pin[i]      = connected[i] ? wave[i] : port_out[i];
      s_d.pin_oe_n[i] = ~port_dir[i];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      s_q                    <= '0;
      s_q.chan_a_output_mode <= 2'(`CTRL_A_RESET >> `CHAN_A_MODE_LO);
      s_q.chan_b_output_mode <= 2'(`CTRL_A_RESET >> `CHAN_B_MODE_LO);
      s_q.wave_mode_sel      <= 2'(`CTRL_A_RESET);
      s_q.wave_mode_msb      <= 1'(`CTRL_B_RESET >> `WAVE_MSB_POS);
      s_q.count_value        <= `COUNT_RESET;
      s_q.cmp_a_buf          <= `CMP_RESET;
      s_q.cmp_a              <= `CMP_RESET;
      s_q.cmp_b_buf          <= `CMP_RESET;
      s_q.cmp_b              <= `CMP_RESET;
      s_q.pin_oe_n           <= 2'h3;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata         = s_q.rdata;
  assign o_pin_a         = s_q.pin[0];
  assign o_pin_b         = s_q.pin[1];
  assign o_pin_a_oe_n    = s_q.pin_oe_n[0];
  assign o_pin_b_oe_n    = s_q.pin_oe_n[1];
  assign o_wave_out_a    = wave[0];
  assign o_wave_out_b    = wave[1];
  assign o_overflow_flag = s_q.overflow_flag;
  assign o_count_value   = s_q.count_value;

endmodule

// ---- sim/timer8_waveform_output_control_properties.sv ----
`timescale 1ns/1ps
module timer8_wave_checker (
  input wire logic       i_ref_clk,
  input wire logic       i_srst,
  input wire logic       i_tick,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_we,
  input wire logic       i_re,
  input wire logic [7:0] o_rdata,
  input wire logic       i_port_out_a,
  input wire logic       i_port_dir_a,
  input wire logic       i_port_out_b,
  input wire logic       i_port_dir_b,
  input wire logic       o_pin_a,
  input wire logic       o_pin_a_oe_n,
  input wire logic       o_pin_b,
  input wire logic       o_pin_b_oe_n,
  input wire logic       o_wave_out_a,
  input wire logic       o_wave_out_b,
  input wire logic       o_overflow_flag,
  input wire logic [7:0] o_count_value
);
  logic [7:0] ctrl_a_q;
  logic       msb_q;
  logic [2:0] mode;

  // Shadow of the mode fields, seen through the write port
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      ctrl_a_q <= 8'h00;
      msb_q    <= 1'b0;
    end else if (i_we && (i_addr == 8'h44 || i_addr == 8'h24)) begin
      ctrl_a_q <= i_wdata;
    end else if (i_we && (i_addr == 8'h45 || i_addr == 8'h25)) begin
      msb_q <= i_wdata[3];
    end
  end
  assign mode = {msb_q, ctrl_a_q[1:0]};

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  sequence max_tick_s;
    (mode == 3'h0 || mode == 3'h3) && i_tick && !i_we
      && o_count_value == 8'hff;
  endsequence
  sequence wrap_s;
    o_overflow_flag && o_count_value == 8'h00;
  endsequence

  reset_clears_a: assert property (disable iff (1'b0)
    i_srst |=> o_count_value == 8'h00 && !o_overflow_flag
      && o_pin_a_oe_n && o_pin_b_oe_n && o_rdata == 8'h00)
    else $error("reset state wrong");
  ctrl_read_a: assert property (
    i_re && (i_addr == 8'h44 || i_addr == 8'h24)
      |=> o_rdata == ($past(ctrl_a_q) & 8'hf3))
    else $error("control read value wrong");
  oe_tracks_dir_a: assert property (
    1'b1 |=> o_pin_a_oe_n == !$past(i_port_dir_a))
    else $error("driver enable wrong");
  wave_routed_a: assert property (
    ctrl_a_q[7] |=> o_pin_a == $past(o_wave_out_a))
    else $error("waveform not on pin");
  port_routed_a: assert property (
    ctrl_a_q[5:4] == 2'b00 |=> o_pin_b == $past(i_port_out_b))
    else $error("port value not on pin");
  max_wrap_a: assert property (max_tick_s |=> wrap_s)
    else $error("no wrap at max");
  flag_cause_a: assert property (o_overflow_flag |-> $past(i_tick))
    else $error("flag without tick");
  count_holds_a: assert property (
    !i_tick && !i_we |=> $stable(o_count_value))
    else $error("count moved without tick");
  pc_top_turn_a: assert property (
    mode == 3'h1 && i_tick && !i_we && o_count_value == 8'hff
      |=> o_count_value == 8'hfe)
    else $error("no turn at top");
  pc_flag_bottom_a: assert property (
    $past(mode) == 3'h1 && o_overflow_flag
      |-> $past(o_count_value) == 8'h00)
    else $error("flag away from bottom");
endmodule

bind timer8_waveform_output_control timer8_wave_checker u_chk (.*);

// ---- sim/timer8_waveform_output_control_bench.sv ----
`timescale 1ns/1ps
module timer8_waveform_output_control_bench;
  logic       i_ref_clk = 1'b0;
  logic       i_srst = 1'b1;
  logic       i_tick = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic       i_we = 1'b0;
  logic       i_re = 1'b0;
  logic       i_port_out_a = 1'b0;
  logic       i_port_dir_a = 1'b0;
  logic       i_port_out_b = 1'b0;
  logic       i_port_dir_b = 1'b0;
  logic [7:0] o_rdata, o_count_value;
  logic       o_pin_a, o_pin_a_oe_n, o_pin_b, o_pin_b_oe_n;
  logic       o_wave_out_a, o_wave_out_b, o_overflow_flag;
  logic [1:0] codes [4] = '{2'h3, 2'h1, 2'h2, 2'h1};
  int         err_total = 0;
  int         n_checks = 0;
  int         cyc = 0;
  logic [7:0] r, d;
  logic       wa;

  timer8_waveform_output_control DUT (.*);

  always #2.5 i_ref_clk = ~i_ref_clk;

  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: byte %h, want %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: bit %b, want %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge i_ref_clk);
    i_addr = a;
    i_wdata = v;
    i_we = 1'b1;
    @(negedge i_ref_clk);
    i_we = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge i_ref_clk);
    i_addr = a;
    i_re = 1'b1;
    @(negedge i_ref_clk);
    i_re = 1'b0;
    v = o_rdata;
  endtask

  task automatic step(input int n);
    repeat (n) begin
      @(negedge i_ref_clk);
      i_tick = 1'b1;
    end
    @(negedge i_ref_clk);
    i_tick = 1'b0;
  endtask

  // Wave level after one non-PWM compare match
  function automatic logic nonpwm(input logic [1:0] c, input logic p);
    case (c)
      2'h1: return ~p;
      2'h2: return 1'b0;
      2'h3: return 1'b1;
      default: return p;
    endcase
  endfunction

  initial begin
    r = 8'($urandom(32'h558b2a8b));
    repeat (8) @(negedge i_ref_clk);
    i_srst = 1'b0;
    rd(8'h44, r);
    chk8(r, 8'h00);
    rd(8'h50, r);
    chk8(r, 8'h00);
    repeat (6) begin
      d = 8'($urandom);
      wr(8'h24, d);
      rd(8'h44, r);
      chk8(r, d & 8'hf3);
    end
    wr(8'h45, 8'h08);
    rd(8'h25, r);
    chk8(r, 8'h08);
    wr(8'h45, 8'h00);
    wr(8'h44, 8'h00);
    i_port_dir_a = 1'b1;
    wr(8'h47, 8'h05);
    wr(8'h48, 8'h05);
    wa = 1'b0;
    foreach (codes[k]) begin
      wr(8'h44, {codes[k], codes[k], 4'h0});
      wr(8'h46, 8'h00);
      step(6);
      wa = nonpwm(codes[k], wa);
      chk1(o_wave_out_a, wa);
      chk1(o_wave_out_b, wa);
      @(negedge i_ref_clk);
      chk1(o_pin_a, wa);
      chk1(o_pin_a_oe_n, 1'b0);
    end
    wr(8'h44, 8'h00);
    i_port_out_a = 1'($urandom);
    i_port_out_b = 1'($urandom);
    repeat (2) @(negedge i_ref_clk);
    chk1(o_pin_a, i_port_out_a);
    chk1(o_pin_b, i_port_out_b);
    chk1(o_pin_b_oe_n, 1'b1);
    wr(8'h44, 8'hb3);
    wr(8'h46, 8'hfe);
    step(2);
    chk1(o_overflow_flag, 1'b1);
    chk8(o_count_value, 8'h00);
    chk1(o_wave_out_a, 1'b1);
    chk1(o_wave_out_b, 1'b0);
    step(6);
    chk1(o_wave_out_a, 1'b0);
    chk1(o_wave_out_b, 1'b1);
    wr(8'h45, 8'h08);
    wr(8'h44, 8'h43);
    wr(8'h46, 8'h00);
    wr(8'h47, 8'h02);
    rd(8'h27, r);
    chk8(r, 8'h02);
    step(6);
    chk8(o_count_value, 8'h00);
    chk1(o_overflow_flag, 1'b1);
    chk1(o_wave_out_a, 1'b1);
    step(3);
    chk8(o_count_value, 8'h00);
    chk1(o_wave_out_a, 1'b0);
    wr(8'h45, 8'h00);
    repeat (2) @(negedge i_ref_clk);
    chk1(o_pin_a, i_port_out_a);
    wr(8'h44, 8'hb1);
    wr(8'h46, 8'h00);
    step(6);
    chk1(o_wave_out_a, 1'b0);
    chk1(o_wave_out_b, 1'b1);
    wr(8'h46, 8'hfd);
    step(3);
    chk8(o_count_value, 8'hfe);
    step(250);
    chk1(o_wave_out_b, 1'b0);
    step(3);
    chk1(o_wave_out_a, 1'b1);
    step(2);
    chk1(o_overflow_flag, 1'b1);
    wr(8'h44, 8'hf1);
    wr(8'h45, 8'h08);
    wr(8'h46, 8'h00);
    step(3);
    chk1(o_wave_out_a, 1'b0);
    wr(8'h44, 8'h83);
    wr(8'h46, 8'h00);
    step(3);
    chk1(o_wave_out_a, 1'b1);
    chk8(o_count_value, 8'h00);
    wr(8'h45, 8'h00);
    wr(8'h44, 8'h13);
    i_port_out_b = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    chk1(o_pin_b, 1'b1);
    wr(8'h44, 8'h02);
    wr(8'h46, 8'h00);
    step(3);
    chk8(o_count_value, 8'h00);
    chk1(o_overflow_flag, 1'b0);
    i_srst = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    i_srst = 1'b0;
    rd(8'h24, r);
    chk8(r, 8'h00);
    print_verdict();
  end
endmodule
